//--- thermistor_temp_monitor_defines.svh
// Constants of the thermistor temperature monitor: offsets, fields,
// reset values and timing counts. Included by the converter and the monitor.
`ifndef THERMISTOR_TEMP_MONITOR_DEFINES_SVH
`define THERMISTOR_TEMP_MONITOR_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_MHZ          100
`define SAR_SETTLE_NS    500
`define SAR_SETTLE_CYC   ((`SAR_SETTLE_NS * `CLK_MHZ + 999) / 1000)

// ---------------------------------------------------------------
// Bus slave address (value arbitrary)
// ---------------------------------------------------------------
`define DEV_ADDR         7'h2a

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_TEMP_READOUT 8'h00
`define REG_IRQ_EN_ONE   8'h05
`define REG_IRQ_EN_TWO   8'h06
`define REG_IRQ_ST_ONE   8'h07
`define REG_IRQ_ST_TWO   8'h08
`define REG_THERM_CFG    8'h0d
`define REG_THRESHOLDS   8'h0e

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_CHANGE       7
`define BIT_HOT          4
`define BIT_COLD         3
`define BIT_EOC          0
`define BIT_TRIGGER      7
`define BIT_CONV_DONE    5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IRQ_EN_ONE_RST   8'h18
`define IRQ_EN_TWO_RST   8'h01
`define CHANGE_THR_RST   2'h1
`define THRESHOLDS_RST   8'hca

// ---------------------------------------------------------------
// Conversion and temperature scale
// ---------------------------------------------------------------
`define ADC_CODE_0C      11'h200
`define ADC_DEG_SHIFT    2
`define TEMP_MIN         8'hf6
`define TEMP_MAX         8'h55
`define COLD_OFFSET      8'hf6
`define HOT_OFFSET       8'h26

`endif

//--- thermistor_pkg.sv
// Types shared by the thermistor temperature monitor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package thermistor_pkg;
   typedef enum logic [3:0] {
      I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_SUB, I2C_SUB_ACK,
      I2C_WR, I2C_WR_ACK, I2C_RD, I2C_MACK
   } i2c_state_t;
   typedef enum logic [1:0] {SAR_IDLE, SAR_SETTLE} sar_state_t;
   typedef logic signed [7:0] temp_t;
endpackage

//--- conv_if.sv
// Conversion handshake between the monitor and its SAR converter.
// Assumes both ends share clock_i.
`timescale 1ns/1ps
interface conv_if;
   logic       start;
   logic       comp;
   logic       busy;
   logic       done;
   logic [9:0] code;
   modport ctrl (output start, comp, input busy, done, code);
   modport adc  (input start, comp, output busy, done, code);
endinterface

//--- bit_sync.sv
// Two-stage synchroniser for signals from outside the clock domain.
// Assumes inputs are levels held for several clock cycles.
`timescale 1ns/1ps
module bit_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_ff;

   // Two flip-flops, first stage read only by the second
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_ff <= '0;
         sync_o  <= '0;
      end else begin
         meta_ff <= async_i;
         sync_o  <= meta_ff;
      end
   end
endmodule

//--- sar_converter.sv
// 10-bit successive-approximation sequencer for the thermistor voltage.
// Assumes an external DAC on dac_code_o and a synchronised comparator
// that is high while the thermistor voltage is at or above the trial.
`timescale 1ns/1ps
`include "thermistor_temp_monitor_defines.svh"
module sar_converter
   import thermistor_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   // Conversion handshake
   conv_if.adc             cv,
   // Trial code to the DAC
   output logic      [9:0] dac_code_o
);
   localparam logic [7:0] SETTLE = 8'(`SAR_SETTLE_CYC);

   sar_state_t state_ff;
   logic [3:0] bit_ff;
   logic [7:0] wait_ff;
   logic [9:0] keep;

   assign cv.busy = (state_ff != SAR_IDLE);
   // Trial with the current bit removed when comparator says too high
   assign keep = cv.comp ? dac_code_o : (dac_code_o & ~(10'h001 << bit_ff));

   // Bit-by-bit search, one settle wait per bit
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff   <= SAR_IDLE;
         bit_ff     <= 4'h0;
         wait_ff    <= 8'h00;
         dac_code_o <= 10'h000;
         cv.code    <= 10'h000;
         cv.done    <= 1'b0;
      end else begin
         cv.done <= 1'b0;
         case (state_ff)
            SAR_IDLE: begin
               if (cv.start) begin
                  state_ff   <= SAR_SETTLE;
                  bit_ff     <= 4'h9;
                  wait_ff    <= SETTLE;
                  dac_code_o <= 10'h200;
               end
            end
            SAR_SETTLE: begin
               if (wait_ff > 8'h01) begin
                  wait_ff <= wait_ff - 8'h01;
               end else if (bit_ff == 4'h0) begin
                  cv.code  <= keep;
                  cv.done  <= 1'b1;
                  state_ff <= SAR_IDLE;
               end else begin
                  dac_code_o <= keep | (10'h001 << (bit_ff - 4'h1));
                  bit_ff     <= bit_ff - 4'h1;
                  wait_ff    <= SETTLE;
               end
            end
            default: state_ff <= SAR_IDLE;
         endcase
      end
   end
endmodule

//--- thermistor_temp_monitor.sv
// Host-triggered panel temperature monitor with I2C register access.
// Assumes open-drain SDA and interrupt pins resolved outside, and an
// external DAC plus comparator around the thermistor divider.
`timescale 1ns/1ps
`include "thermistor_temp_monitor_defines.svh"
module thermistor_temp_monitor
   import thermistor_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   // I2C pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // Wake pin
   input  wire logic       wake_pin_i,
   // Converter analog front end
   input  wire logic       comp_i,
   output logic      [9:0] dac_code_o,
   // Interrupt pin, open drain
   output logic            irq_pin_n_o,
   output logic            irq_pin_n_oe_o
);

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   logic [3:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       wake_s;
   logic       scl_d_ff;
   logic       sda_d_ff;
   logic       wake_d_ff;

   // Bus pins synchronised inverted so the reset value matches the idle high
   bit_sync #(.W(4)) u_sync (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .async_i ({comp_i, wake_pin_i, ~sda_i, ~scl_i}),
      .sync_o  (pins_s)
   );

   assign scl_s  = ~pins_s[0];
   assign sda_s  = ~pins_s[1];
   assign wake_s = pins_s[2];

   // Delayed copies for edge detection
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
         wake_d_ff <= 1'b0;
      end else begin
         scl_d_ff  <= scl_s;
         sda_d_ff  <= sda_s;
         wake_d_ff <= wake_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic wake_rise;

   assign scl_rise  = scl_s & ~scl_d_ff;
   assign scl_fall  = ~scl_s & scl_d_ff;
   assign bus_start = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
   assign bus_stop  = scl_s & scl_d_ff & sda_s & ~sda_d_ff;
   assign wake_rise = wake_s & ~wake_d_ff;

   // ---------------------------------------------------------------
   // I2C slave
   // ---------------------------------------------------------------
   i2c_state_t st_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [3:0] cnt_ff;
   logic [7:0] ptr_ff;
   logic       rnw_ff;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rd_data;

   // Strobes for register access, used by the register file
   assign wr_stb = scl_fall && (st_ff == I2C_WR) && (cnt_ff == 4'h8);
   assign rd_stb = scl_fall && ((st_ff == I2C_ADDR_ACK && rnw_ff) ||
                                (st_ff == I2C_MACK));
   assign sda_o  = 1'b0;

   // Byte framing, acknowledge and address pointer
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff    <= I2C_IDLE;
         shift_ff <= 8'h00;
         tx_ff    <= 8'h00;
         cnt_ff   <= 4'h0;
         ptr_ff   <= 8'h00;
         rnw_ff   <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (bus_start) begin
         st_ff    <= I2C_ADDR;
         cnt_ff   <= 4'h0;
         sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
         st_ff    <= I2C_IDLE;
         sda_oe_o <= 1'b0;
      end else begin
         case (st_ff)
            I2C_ADDR, I2C_SUB, I2C_WR: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                  cnt_ff   <= cnt_ff + 4'h1;
               end else if (scl_fall && cnt_ff == 4'h8) begin
                  cnt_ff <= 4'h0;
                  if (st_ff == I2C_ADDR) begin
                     if (shift_ff[7:1] == `DEV_ADDR) begin
                        rnw_ff   <= shift_ff[0];
                        sda_oe_o <= 1'b1;
                        st_ff    <= I2C_ADDR_ACK;
                     end else begin
                        st_ff <= I2C_IDLE;
                     end
                  end else if (st_ff == I2C_SUB) begin
                     ptr_ff   <= shift_ff;
                     sda_oe_o <= 1'b1;
                     st_ff    <= I2C_SUB_ACK;
                  end else begin
                     sda_oe_o <= 1'b1;
                     st_ff    <= I2C_WR_ACK;
                  end
               end
            end
            I2C_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_ff <= 4'h0;
                  if (rnw_ff) begin
                     tx_ff    <= rd_data;
                     sda_oe_o <= ~rd_data[7];
                     ptr_ff   <= ptr_ff + 8'h01;
                     st_ff    <= I2C_RD;
                  end else begin
                     sda_oe_o <= 1'b0;
                     st_ff    <= I2C_SUB;
                  end
               end
            end
            I2C_SUB_ACK, I2C_WR_ACK: begin
               if (scl_fall) begin
                  sda_oe_o <= 1'b0;
                  st_ff    <= I2C_WR;
                  if (st_ff == I2C_WR_ACK) begin
                     ptr_ff <= ptr_ff + 8'h01;
                  end
               end
            end
            I2C_RD: begin
               if (scl_rise) begin
                  cnt_ff <= cnt_ff + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_ff == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     st_ff    <= I2C_MACK;
                  end else begin
                     tx_ff    <= {tx_ff[6:0], 1'b1};
                     sda_oe_o <= ~tx_ff[6];
                  end
               end
            end
            I2C_MACK: begin
               if (scl_rise && sda_s) begin
                  st_ff <= I2C_IDLE;  // Master nack ends the read
               end else if (scl_fall) begin
                  cnt_ff   <= 4'h0;
                  tx_ff    <= rd_data;
                  sda_oe_o <= ~rd_data[7];
                  ptr_ff   <= ptr_ff + 8'h01;
                  st_ff    <= I2C_RD;
               end
            end
            default: st_ff <= I2C_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Converter and translation to degrees
   // ---------------------------------------------------------------
   conv_if cv ();

   sar_converter u_sar (
      .clock_i    (clock_i),
      .nrst_i     (nrst_i),
      .cv         (cv),
      .dac_code_o (dac_code_o)
   );

   logic        trig_ff;
   logic        start_ff;
   logic [10:0] diff;
   logic [10:0] deg_wide;
   temp_t       deg;

   assign cv.start = start_ff;
   assign cv.comp  = pins_s[3];

   // Voltage falls as temperature rises; four codes per degree
   always_comb begin
      diff     = `ADC_CODE_0C - {1'b0, cv.code};
      deg_wide = $signed(diff) >>> `ADC_DEG_SHIFT;
      if ($signed(deg_wide) <= $signed({{3{1'b1}}, `TEMP_MIN})) begin
         deg = `TEMP_MIN;
      end else if ($signed(deg_wide) >= $signed({3'b000, `TEMP_MAX})) begin
         deg = `TEMP_MAX;
      end else begin
         deg = deg_wide[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   temp_t      temp_ff;
   logic [1:0] dt_ff;
   logic [7:0] thr_ff;
   logic [7:0] en1_ff;
   logic [7:0] en2_ff;
   logic       conv_done;
   logic       st_chg_ff;
   logic       st_hot_ff;
   logic       st_cold_ff;
   logic       st_eoc_ff;

   assign conv_done = ~(cv.busy | trig_ff | start_ff);

   // Writable configuration
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dt_ff  <= `CHANGE_THR_RST;
         thr_ff <= `THRESHOLDS_RST;
         en1_ff <= `IRQ_EN_ONE_RST;
         en2_ff <= `IRQ_EN_TWO_RST;
      end else if (wr_stb) begin
         case (ptr_ff)
            `REG_THERM_CFG:  dt_ff  <= shift_ff[1:0];
            `REG_THRESHOLDS: thr_ff <= shift_ff;
            `REG_IRQ_EN_ONE: en1_ff <= shift_ff & `IRQ_EN_ONE_RST | shift_ff &
                                       8'h80;
            `REG_IRQ_EN_TWO: en2_ff <= shift_ff & `IRQ_EN_TWO_RST;
            default: ;
         endcase
      end
   end

   // Trigger bit: accepted only when idle, then clears itself
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trig_ff  <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         if (trig_ff) begin
            trig_ff  <= 1'b0;
            start_ff <= 1'b1;
         end else if (wr_stb && ptr_ff == `REG_THERM_CFG &&
                      shift_ff[`BIT_TRIGGER] && !cv.busy && !start_ff) begin
            trig_ff <= 1'b1;
         end
      end
   end

   // Read data selection
   always_comb begin
      rd_data = 8'h00;
      case (ptr_ff)
         `REG_TEMP_READOUT: rd_data = temp_ff;
         `REG_IRQ_EN_ONE:   rd_data = en1_ff;
         `REG_IRQ_EN_TWO:   rd_data = en2_ff;
         `REG_IRQ_ST_ONE:   rd_data = {st_chg_ff, 2'b00, st_hot_ff, st_cold_ff, 3'b000};
         `REG_IRQ_ST_TWO:   rd_data = {7'h00, st_eoc_ff};
         `REG_THERM_CFG: begin
            rd_data                = {6'h00, dt_ff};
            rd_data[`BIT_TRIGGER]  = trig_ff;
            rd_data[`BIT_CONV_DONE] = conv_done;
         end
         `REG_THRESHOLDS:   rd_data = thr_ff;
         default:           rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Reading evaluation
   // ---------------------------------------------------------------
   temp_t      base_ff;
   logic       base_ok_ff;
   temp_t      hot_deg;
   temp_t      cold_deg;
   logic [8:0] delta;
   logic [8:0] delta_abs;
   logic       is_hot;
   logic       is_cold;
   logic       is_chg;

   // Four-bit thresholds mapped into degrees
   assign hot_deg   = {4'h0, thr_ff[7:4]} + `HOT_OFFSET;
   assign cold_deg  = {4'h0, thr_ff[3:0]} + `COLD_OFFSET;
   assign delta     = {deg[7], deg} - {base_ff[7], base_ff};
   assign delta_abs = delta[8] ? (9'h000 - delta) : delta;
   assign is_hot    = (deg >= hot_deg);
   assign is_cold   = (deg <= cold_deg);
   assign is_chg    = base_ok_ff &&
                      (delta_abs >= {6'h00, 1'b0, dt_ff} + 9'h001);

   // Readout and baseline
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         temp_ff    <= 8'h00;
         base_ff    <= 8'h00;
         base_ok_ff <= 1'b0;
      end else begin
         if (cv.done) begin
            temp_ff <= deg;
         end
         if (wake_rise) begin
            base_ok_ff <= 1'b0;
         end else if (cv.done && (!base_ok_ff || is_chg)) begin
            base_ff    <= deg;
            base_ok_ff <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags, clear on read, set wins
   // ---------------------------------------------------------------
   logic clr_one;
   logic clr_two;

   assign clr_one = rd_stb && (ptr_ff == `REG_IRQ_ST_ONE);
   assign clr_two = rd_stb && (ptr_ff == `REG_IRQ_ST_TWO);

   // Flags set independent of enables
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_chg_ff  <= 1'b0;
         st_hot_ff  <= 1'b0;
         st_cold_ff <= 1'b0;
         st_eoc_ff  <= 1'b0;
      end else begin
         st_chg_ff  <= (cv.done && is_chg) | (st_chg_ff & ~clr_one);
         st_hot_ff  <= (cv.done && is_hot) | (st_hot_ff & ~clr_one);
         st_cold_ff <= (cv.done && is_cold) | (st_cold_ff & ~clr_one);
         st_eoc_ff  <= cv.done | (st_eoc_ff & ~clr_two);
      end
   end

   // ---------------------------------------------------------------
   // Interrupt pin
   // ---------------------------------------------------------------
   logic irq_any;

   // Enables gate the pin only
   assign irq_any = (st_chg_ff & en1_ff[`BIT_CHANGE]) |
                    (st_hot_ff & en1_ff[`BIT_HOT]) |
                    (st_cold_ff & en1_ff[`BIT_COLD]) |
                    (st_eoc_ff & en2_ff[`BIT_EOC]);

   // Registered open-drain drive
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_pin_n_oe_o <= 1'b0;
      end else begin
         irq_pin_n_oe_o <= irq_any;
      end
   end

   assign irq_pin_n_o = 1'b0;

endmodule

//--- ttm_assertions.sv
// Pin assertions for the thermistor monitor.
// Assumes a bind into the top module.
`timescale 1ns/1ps
module ttm_assertions (
   input wire logic       clock_i,
   input wire logic       nrst_i,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic [9:0] dac_code_o,
   input wire logic       irq_pin_n_o,
   input wire logic       irq_pin_n_oe_o
);
   // --
   // Pin checks
   // --
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   // Acknowledge or data low held for four cycles after it starts
   sequence s_ack_hold;
      sda_oe_o [*4];
   endsequence
   a_sda_open_drain: assert property (sda_o == 1'b0) else $error("sda high");
   a_irq_open_drain: assert property (irq_pin_n_o == 1'b0) else $error("irq high");
   a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda moved");
   a_ack_stands: assert property ($rose(sda_oe_o) |=> s_ack_hold) else $error("ack short");
   a_irq_clear_edge: assert property ($fell(irq_pin_n_oe_o) |-> !scl_i) else $error("irq off");
   a_reset_bus_idle: assert property ($rose(nrst_i) |-> !sda_oe_o ##1 !sda_oe_o)
      else $error("sda at reset");
   a_reset_no_conv: assert property ($rose(nrst_i) |-> dac_code_o == 10'h000 && !irq_pin_n_oe_o)
      else $error("busy at reset");
   a_trial_hold: assert property ($changed(dac_code_o) && dac_code_o != 10'h000
      |=> $stable(dac_code_o) [*8]) else $error("trial short");
endmodule
bind thermistor_temp_monitor ttm_assertions u_ttm_assertions (.clock_i(clock_i),
   .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .dac_code_o(dac_code_o), .irq_pin_n_o(irq_pin_n_o), .irq_pin_n_oe_o(irq_pin_n_oe_o));

//--- ttm_host.sv
// Host model: bus master on open-drain SDA with a pull-up.
// Assumes the device enable is high while it pulls SDA low.
`timescale 1ns/1ps
module ttm_host (
   // Clock and device side
   input  wire logic clock_i,
   input  wire logic sda_oe_i,
   // Bus wires
   output logic      scl_o,
   output logic      sda_o
);
   // --
   // Wires and bit timing
   // --
   logic m_sda;
   // Wired-AND, pulled up when released
   assign sda_o = m_sda & ~sda_oe_i;
   initial begin
      scl_o = 1'b1;
      m_sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Start or repeated start: SDA falls with SCL high
   task automatic start();
      m_sda <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(6);
      m_sda <= 1'b0;
      tick(6);
      scl_o <= 1'b0;
      tick(4);
   endtask
   // Stop: SDA rises with SCL high
   task automatic stop();
      m_sda <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(6);
      m_sda <= 1'b1;
      tick(6);
   endtask
   // One bit, data changed only with SCL low
   task automatic bit1(input logic b, output logic g);
      m_sda <= b;
      tick(4);
      scl_o <= 1'b1;
      tick(6);
      g = sda_o;
      scl_o <= 1'b0;
      tick(4);
   endtask
   // Byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                       output logic g);
      for (int b = 7; b >= 0; b--)
         bit1(d[b], q[b]);
      bit1(ak, g);
   endtask
endmodule

//--- thermistor_temp_monitor_tb.sv
// Bench: host model on the bus, comparator model on the converter.
// Assumes the design, ttm_host and ttm_assertions compiled first.
`timescale 1ns/1ps
module thermistor_temp_monitor_tb
   import thermistor_pkg::*;
;
   // --
   // Signals, models and scoreboard
   // --
   logic       clock_i, nrst_i, wake_pin_i, comp_i, scl, sda, sda_o, sda_oe_o;
   logic       irq_o, irq_oe, have_base;
   logic [9:0] dac_code_o, target;
   logic [7:0] exp_q[$], got_q[$], st;
   logic [1:0] fld;
   string      nm_q[$];
   int         n_mismatch, checked, seed, i, d;
   temp_t      t, base;
   thermistor_temp_monitor u_thermistor_temp_monitor (.clock_i(clock_i), .nrst_i(nrst_i),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wake_pin_i(wake_pin_i),
      .comp_i(comp_i), .dac_code_o(dac_code_o), .irq_pin_n_o(irq_o), .irq_pin_n_oe_o(irq_oe));
   ttm_host u_ttm_host (.clock_i(clock_i), .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // Comparator: high while the thermistor level is at or above the trial
   always @(posedge clock_i) comp_i <= target >= dac_code_o;
   // Oldest expectation against each result
   initial forever begin
      wait (got_q.size() > 0);
      cmp(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
   end
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic note(input string n, input logic [7:0] e);
      nm_q.push_back(n);
      exp_q.push_back(e);
   endtask
   // Byte that the device must acknowledge
   task automatic snd(input logic [7:0] v);
      logic [7:0] r;
      logic       g;
      note("ack", 8'h00);
      u_ttm_host.xfer(v, 1'b1, r, g);
      got_q.push_back({7'h00, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      u_ttm_host.start();
      snd(8'h54);
      snd(a);
      snd(v);
      u_ttm_host.stop();
   endtask
   // Read n bytes from a, expected bytes packed from the top of e
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input int n);
      logic [7:0] r;
      logic       g;
      u_ttm_host.start();
      snd(8'h54);
      snd(a);
      u_ttm_host.start();
      snd(8'h55);
      for (int j = 0; j < n; j++) begin
         note("reg", e[31-8*j -: 8]);
         u_ttm_host.xfer(8'hff, j == n - 1, r, g);
         got_q.push_back(r);
      end
      u_ttm_host.stop();
   endtask
   task automatic irq(input logic e);
      note("irq", {7'h00, e});
      #1;
      got_q.push_back({7'h00, irq_oe});
   endtask
   // Main sequence
   initial begin
      seed = 32'heb2b;
      {nrst_i, wake_pin_i, comp_i, target, have_base} = '0;
      u_ttm_host.tick(8);
      nrst_i <= 1'b1;
      u_ttm_host.tick(8);
      rd(8'h05, 32'h18010000, 4);
      rd(8'h0d, 32'h21ca0000, 3);
      wr(8'h00, 8'h7f);
      wake_pin_i <= 1'b1;
      for (i = 0; i < 12; i++) begin
         if (i == 6) begin
            wr(8'h05, 8'h00);
            wr(8'h06, 8'h00);
            wake_pin_i <= 1'b0;
            u_ttm_host.tick(8);
            wake_pin_i <= 1'b1;
            have_base = 1'b0;
         end
         target <= 10'($random(seed));
         fld = i[1:0];
         wr(8'h0d, {6'h20, fld});
         rd(8'h0d, {6'h00, fld, 24'h0}, 1);
         u_ttm_host.tick(600);
         irq(i < 6);
         d = (512 - int'(target)) >>> 2;
         t = (d < -10) ? -8'sd10 : (d > 85) ? 8'sd85 : temp_t'(d);
         d = t - base;
         if (d < 0)
            d = -d;
         st = {have_base && d >= fld + 1, 2'b00, t >= 50, t <= 0, 3'b000};
         if (!have_base || st[7])
            base = t;
         have_base = 1'b1;
         rd(8'h00, {t, 24'h0}, 1);
         rd(8'h07, {st, 8'h01, 16'h0}, 2);
         if (st[4:3] == 2'b00)
            irq(1'b0);
      end
      u_ttm_host.tick(2);
      close_out();
   end
endmodule
